// ---- rtl/xid_exec.sv ----
// Purpose: Decode and execute of the eight-instruction pointer/stack extension
// Assumes: One instruction word presented per cycle with word_valid_in
// Notes:   Outputs are registered strobes and values for the core datapaths
//
// Overview of operation
// - The 6-bit unsigned literal is added to the whole selected pointer 0, 1 or 2.
// - Selector 11 adds the literal to the frame pointer then returns through the stack top.
// - The add-and-return takes two cycles, the second being idle while fetching.
// - Word 0014 is a call through the working register, two cycles, flags untouched.
// - EB with bit7 clear is a two-word move from indexed source to a 12-bit address.
// - EB with bit7 set is a two-word move from indexed source to indexed destination.
// - Upper byte EA pushes an 8-bit literal in one cycle, flags untouched.
// - Upper byte E9 with selector not 11 subtracts a literal from a pointer in one cycle.
// - E9 with selector 11 subtracts from the frame pointer then returns, two cycles.
// - The extension is recognised only when the configuration enable is set.
// - The call pushes the next address and, in the same cycle, loads PC from latches and the working register.
// - Push writes the literal at the frame pointer address then decrements it by one.
// - Indexed addresses are frame pointer plus offset; indirect-register sources read zero.
`timescale 1ns/1ps
`default_nettype none
`include "xid_defs.svh"
module xid_exec
    import xid_pkg::*;
#(
    parameter int PTR_W = 12,
    parameter int PC_W  = 21
) (
    input  wire logic             clk_in,            // 40 MHz core clock
    input  wire logic             reset_n_in,        // Synchronous reset, active low
    input  wire logic             ext_set_config_bit_in, // Extension enable
    input  wire logic             word_valid_in,     // Word fetched this cycle
    input  wire logic [15:0]      word_in,           // Fetched word
    input  wire logic [PC_W-1:0]  pc_in,             // Address of current word
    input  wire logic [PTR_W-1:0] ptr0_in,           // Pointer 0
    input  wire logic [PTR_W-1:0] ptr1_in,           // Pointer 1
    input  wire logic [PTR_W-1:0] ptr2_in,           // Frame pointer
    input  wire logic [PC_W-1:0]  stack_top_in,      // Return stack top
    input  wire logic [7:0]       working_reg_in,    // Working register
    input  wire logic [7:0]       pc_latch_high_in,  // PC latch high
    input  wire logic [4:0]       pc_latch_upper_in, // PC latch upper
    input  wire logic [7:0]       rd_data_in,        // Data read result
    output logic                  handled_out,       // Word taken by extension
    output logic                  ptr_we_out,        // Pointer write strobe
    output logic [1:0]            ptr_sel_out,       // Pointer written
    output logic [PTR_W-1:0]      ptr_wdata_out,     // Pointer value
    output logic                  pc_load_out,       // Load PC strobe
    output logic [PC_W-1:0]       pc_wdata_out,      // New PC
    output logic                  push_out,          // Return stack push
    output logic [PC_W-1:0]       push_data_out,     // Pushed address
    output logic                  rd_en_out,         // Data read strobe
    output logic [PTR_W-1:0]      rd_addr_out,       // Data read address
    output logic                  wr_en_out,         // Data write strobe
    output logic [PTR_W-1:0]      wr_addr_out,       // Data write address
    output logic [7:0]            wr_data_out,       // Data write value
    output logic                  stall_fetch_out    // Next word is not an instruction
);
    // ****************************************
    // Decode
    // ****************************************
    xid_decode_if dec_bus ();
    xid_decoder xid_decoder_inst (
        .word_in   (word_in),
        .enable_in (ext_set_config_bit_in),
        .dec_out   (dec_bus)
    );

    xid_state_type state_reg;
    xid_state_type state_next;
    logic          movs_reg;
    logic [7:0]    src_data_reg;
    logic [PTR_W-1:0] src_addr_reg;

    localparam logic [7:0] INDIRECT_HI = `XID_INDIRECT_HI;

    function automatic logic [PTR_W-1:0] idx(input logic [PTR_W-1:0] base, input logic [6:0] off);
        idx = base + PTR_W'(off);
    endfunction

    function automatic logic is_indirect(input logic [PTR_W-1:0] a);
        is_indirect = (a[7:0] >= {INDIRECT_HI[7:4], `XID_INDIRECT_LO_MIN})
                      && (a[PTR_W-1:8] == '1);
    endfunction

    wire logic in_decode = (state_reg == XID_ST_DECODE);
    wire logic go        = in_decode && word_valid_in;
    wire xid_op_type op  = dec_bus.op;
    wire logic [PTR_W-1:0] sel_ptr =
        (dec_bus.sel == 2'h0) ? ptr0_in : (dec_bus.sel == 2'h1) ? ptr1_in : ptr2_in;
    wire logic [PTR_W-1:0] lit_ext  = PTR_W'(dec_bus.lit6);
    wire logic [PTR_W-1:0] add_sum  = sel_ptr + lit_ext;
    wire logic [PTR_W-1:0] sub_diff = sel_ptr - lit_ext;
    wire logic [PTR_W-1:0] src_addr = idx(ptr2_in, dec_bus.offset);
    wire logic [PTR_W-1:0] dst_addr = idx(ptr2_in, word_in[6:0]);
    wire logic is_ret  = (op == XID_OP_ADDR) || (op == XID_OP_SUBR);
    wire logic is_ptr  = is_ret || (op == XID_OP_ADDP) || (op == XID_OP_SUBP);
    wire logic is_move = (op == XID_OP_MOVF) || (op == XID_OP_MOVS);
    wire logic [7:0] src_value = is_indirect(src_addr_reg) ? 8'h00 : rd_data_in;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            XID_ST_DECODE: begin
                if (go && (is_ret || op == XID_OP_CALL_VIA_WORKING_REG)) begin
                    state_next = XID_ST_IDLE2;
                end else if (go && is_move) begin
                    state_next = XID_ST_WORD2;
                end
            end
            XID_ST_IDLE2: state_next = XID_ST_DECODE;
            XID_ST_WORD2: begin
                if (word_valid_in) begin
                    state_next = XID_ST_DECODE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_reg <= XID_ST_DECODE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            movs_reg     <= 1'b0;
            src_addr_reg <= '0;
        end else if (go && is_move) begin
            movs_reg     <= (op == XID_OP_MOVS);
            src_addr_reg <= src_addr;
        end
    end

    // Source byte is taken from rd_data_in in the same cycle that the read strobe is high
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            src_data_reg <= 8'h00;
        end else if (rd_en_out) begin
            src_data_reg <= src_value;
        end
    end

    // ****************************************
    // Datapath strobes
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            handled_out   <= 1'b0;
            ptr_we_out    <= 1'b0;
            ptr_sel_out   <= 2'h0;
            ptr_wdata_out <= '0;
            pc_load_out   <= 1'b0;
            pc_wdata_out  <= '0;
            push_out      <= 1'b0;
            push_data_out <= '0;
            rd_en_out     <= 1'b0;
            rd_addr_out   <= '0;
            wr_en_out     <= 1'b0;
            wr_addr_out   <= '0;
            wr_data_out   <= 8'h00;
            stall_fetch_out <= 1'b0;
        end else begin
            handled_out <= (go && op != XID_OP_NONE) || (state_reg == XID_ST_WORD2 && word_valid_in);
            ptr_we_out  <= go && (is_ptr || op == XID_OP_PUSH);
            ptr_sel_out <= (is_ret || op == XID_OP_PUSH) ? 2'h2 : dec_bus.sel;
            ptr_wdata_out <= (op == XID_OP_PUSH) ? ptr2_in - PTR_W'(1) :
                             (op == XID_OP_ADDP || op == XID_OP_ADDR) ? add_sum : sub_diff;
            pc_load_out <= go && (is_ret || op == XID_OP_CALL_VIA_WORKING_REG);
            pc_wdata_out <= (op == XID_OP_CALL_VIA_WORKING_REG) ?
                            {pc_latch_upper_in, pc_latch_high_in, working_reg_in} : stack_top_in;
            push_out      <= go && (op == XID_OP_CALL_VIA_WORKING_REG);
            push_data_out <= pc_in + PC_W'(`XID_PC_STEP);
            rd_en_out   <= go && is_move;
            rd_addr_out <= src_addr;
            wr_en_out   <= (go && op == XID_OP_PUSH) ||
                           (state_reg == XID_ST_WORD2 && word_valid_in &&
                            word_in[15:12] == `XID_SECOND_NIBBLE &&
                            !(movs_reg && is_indirect(dst_addr)));
            wr_addr_out <= in_decode ? ptr2_in : (movs_reg ? dst_addr : word_in[PTR_W-1:0]);
            // Source byte still on rd_data_in when the second word follows at once
            wr_data_out <= in_decode ? dec_bus.lit8 : (rd_en_out ? src_value : src_data_reg);
            stall_fetch_out <= state_next != XID_ST_DECODE;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_ret_two_cycles;
        @(posedge clk_in) disable iff (!reset_n_in)
        (go && is_ret) |=> (state_reg == XID_ST_IDLE2) ##1 (state_reg == XID_ST_DECODE);
    endproperty
    a_ret_two_cycles: assert property (p_ret_two_cycles) else $error("return not two cycles");

    property p_call_push;
        @(posedge clk_in) disable iff (!reset_n_in)
        (go && op == XID_OP_CALL_VIA_WORKING_REG) |=> push_out && pc_load_out && push_data_out == $past(pc_in) + 21'h2;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_add_sum;
        @(posedge clk_in) disable iff (!reset_n_in)
        (go && op == XID_OP_ADDP) |=> ptr_we_out && ptr_wdata_out == $past(add_sum);
    endproperty
    a_add_sum: assert property (p_add_sum) else $error("pointer add wrong");

    property p_push_dec;
        @(posedge clk_in) disable iff (!reset_n_in)
        (go && op == XID_OP_PUSH) |=> wr_en_out && wr_addr_out == $past(ptr2_in)
            && ptr_wdata_out == $past(ptr2_in) - 12'h1;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push wrong");

    property p_disabled;
        @(posedge clk_in) disable iff (!reset_n_in)
        (go && !ext_set_config_bit_in) |=> !handled_out && !ptr_we_out;
    endproperty
    a_disabled: assert property (p_disabled) else $error("extension active while disabled");

    property p_move_second;
        @(posedge clk_in) disable iff (!reset_n_in)
        (go && is_move) |=> rd_en_out && state_reg == XID_ST_WORD2;
    endproperty
    a_move_second: assert property (p_move_second) else $error("move sequence wrong");

    property p_ret_pc;
        @(posedge clk_in) disable iff (!reset_n_in)
        (go && op == XID_OP_SUBR) |=> pc_load_out && pc_wdata_out == $past(stack_top_in) && ptr_sel_out == 2'h2;
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("sub return wrong");

    property p_word2_consumed;
        @(posedge clk_in) disable iff (!reset_n_in)
        (state_reg == XID_ST_WORD2 && word_valid_in) |=> !ptr_we_out && !pc_load_out;
    endproperty
    a_word2_consumed: assert property (p_word2_consumed) else $error("second word executed");
endmodule : xid_exec
`default_nettype wire

// ---- rtl/xid_defs.svh ----
// Purpose: Constants for the extended instruction decode/execute block
// Assumes: 16-bit instruction words, 12-bit data addresses, 21-bit program counter
// Notes:   Included by the modules and the testbench
`ifndef XID_DEFS_SVH
`define XID_DEFS_SVH

`define XID_OP_ADD_PTR      8'hE8
`define XID_OP_SUB_PTR      8'hE9
`define XID_OP_PUSH_LIT     8'hEA
`define XID_OP_MOVE_IDX     8'hEB
`define XID_WORD_CALL_W     16'h0014
`define XID_SECOND_NIBBLE   4'hF
`define XID_SEL_FRAME       2'h3
`define XID_PC_STEP         21'h000002
`define XID_INDIRECT_HI     8'hFE
`define XID_INDIRECT_LO_MIN 4'hB

`endif

// ---- rtl/xid_pkg.sv ----
// Purpose: Types for the extended instruction decode/execute block
// Assumes: xid_defs.svh constants
// Notes:   States are one-hot
package xid_pkg;
    typedef enum logic [2:0] {
        XID_ST_DECODE = 3'b001,
        XID_ST_IDLE2  = 3'b010,
        XID_ST_WORD2  = 3'b100
    } xid_state_type;

    typedef enum logic [3:0] {
        XID_OP_NONE  = 4'h0,
        XID_OP_ADDP  = 4'h1,
        XID_OP_ADDR  = 4'h2,
        XID_OP_SUBP  = 4'h3,
        XID_OP_SUBR  = 4'h4,
        XID_OP_CALL_VIA_WORKING_REG = 4'h5,
        XID_OP_MOVF  = 4'h6,
        XID_OP_MOVS  = 4'h7,
        XID_OP_PUSH  = 4'h8
    } xid_op_type;
endpackage : xid_pkg

// ---- rtl/xid_decode_if.sv ----
// Purpose: Carries decode result from the decoder to the executor
// Assumes: Same clock domain
// Notes:   Purely combinational signal bundle
`timescale 1ns/1ps
`default_nettype none
interface xid_decode_if;
    import xid_pkg::*;
    xid_op_type op;
    logic [1:0] sel;
    logic [5:0] lit6;
    logic [7:0] lit8;
    logic [6:0] offset;
    modport dec  (output op, sel, lit6, lit8, offset);
    modport exec (input  op, sel, lit6, lit8, offset);
endinterface : xid_decode_if
`default_nettype wire

// ---- rtl/xid_decoder.sv ----
// Purpose: Classifies a fetched word as one of the eight extended instructions
// Assumes: Extension enable is stable after programming
// Notes:   Returns none when the extension is disabled
`timescale 1ns/1ps
`default_nettype none
`include "xid_defs.svh"
module xid_decoder
    import xid_pkg::*;
(
    input  wire logic [15:0] word_in,      // Fetched instruction word
    input  wire logic        enable_in,    // Extension enabled
    xid_decode_if.dec        dec_out       // Decode result
);
    wire logic [7:0] hi_byte = word_in[15:8];
    wire logic [1:0] sel     = word_in[7:6];
    wire logic       is_frame = (sel == `XID_SEL_FRAME);

    assign dec_out.sel    = sel;
    assign dec_out.lit6   = word_in[5:0];
    assign dec_out.lit8   = word_in[7:0];
    assign dec_out.offset = word_in[6:0];
    assign dec_out.op =
        !enable_in                                  ? XID_OP_NONE :
        (word_in == `XID_WORD_CALL_W)               ? XID_OP_CALL_VIA_WORKING_REG :
        (hi_byte == `XID_OP_ADD_PTR)  ? (is_frame ? XID_OP_ADDR : XID_OP_ADDP) :
        (hi_byte == `XID_OP_SUB_PTR)  ? (is_frame ? XID_OP_SUBR : XID_OP_SUBP) :
        (hi_byte == `XID_OP_PUSH_LIT) ? XID_OP_PUSH :
        (hi_byte == `XID_OP_MOVE_IDX) ? (word_in[7] ? XID_OP_MOVS : XID_OP_MOVF) :
                                        XID_OP_NONE;
endmodule : xid_decoder
`default_nettype wire

// ---- bench/extended_isa_decode_execute_tb.sv ----
// Purpose: Self-checking bench for the extended instruction decode/execute block
// Assumes: Inputs driven on the falling edge, outputs registered on the taking edge and checked at the next falling edge
// Notes:   Bench drives the core-side datapath values directly
`timescale 1ns/1ps
`default_nettype none
`include "xid_defs.svh"
module extended_isa_decode_execute_tb;
    import xid_pkg::*;

    // ************************************************************
    // Signals and design instance
    // ************************************************************
    logic        clk_in, reset_n_in, ext_set_config_bit_in, word_valid_in;
    logic [15:0] word_in;
    logic [20:0] pc_in, stack_top_in;
    logic [11:0] ptr0_in, ptr1_in, ptr2_in;
    logic [7:0]  working_reg_in, pc_latch_high_in, rd_data_in;
    logic [4:0]  pc_latch_upper_in;
    logic        handled_out, ptr_we_out, pc_load_out, push_out, rd_en_out, wr_en_out, stall_fetch_out;
    logic [1:0]  ptr_sel_out;
    logic [11:0] ptr_wdata_out, rd_addr_out, wr_addr_out;
    logic [20:0] pc_wdata_out, push_data_out;
    logic [7:0]  wr_data_out;
    int          error_cnt    = 0;
    int          total_checks = 0;

    xid_exec xid_exec_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .ext_set_config_bit_in(ext_set_config_bit_in), .word_valid_in(word_valid_in), .word_in(word_in),
        .pc_in(pc_in), .ptr0_in(ptr0_in), .ptr1_in(ptr1_in), .ptr2_in(ptr2_in), .stack_top_in(stack_top_in),
        .working_reg_in(working_reg_in), .pc_latch_high_in(pc_latch_high_in),
        .pc_latch_upper_in(pc_latch_upper_in), .rd_data_in(rd_data_in), .handled_out(handled_out),
        .ptr_we_out(ptr_we_out), .ptr_sel_out(ptr_sel_out), .ptr_wdata_out(ptr_wdata_out),
        .pc_load_out(pc_load_out), .pc_wdata_out(pc_wdata_out), .push_out(push_out),
        .push_data_out(push_data_out), .rd_en_out(rd_en_out), .rd_addr_out(rd_addr_out),
        .wr_en_out(wr_en_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
        .stall_fetch_out(stall_fetch_out));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic issue(input logic [15:0] w);
        @(negedge clk_in);
        word_in       = w;
        word_valid_in = 1'b1;
        @(negedge clk_in);
        word_valid_in = 1'b0;
    endtask

    task automatic conclude;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_ptr_arith;
        logic [5:0]  k;
        logic [11:0] base;
        for (int op = 0; op < 2; op++) begin
            for (int i = 0; i < 3; i++) begin
                k    = 6'h3F - i[5:0];
                base = (i == 0) ? ptr0_in : (i == 1) ? ptr1_in : ptr2_in;
                issue({(op == 0) ? `XID_OP_ADD_PTR : `XID_OP_SUB_PTR, i[1:0], k});
                chk(handled_out, 1'b1);
                chk(ptr_we_out, 1'b1);
                chk(ptr_sel_out, i[1:0]);
                chk(ptr_wdata_out, 12'((op == 0) ? base + k : base - k));
                chk({pc_load_out, wr_en_out, stall_fetch_out}, 3'h0);
            end
        end
    endtask

    task automatic t_return(input logic sub);
        @(negedge clk_in);
        word_in       = {sub ? `XID_OP_SUB_PTR : `XID_OP_ADD_PTR, 2'h3, 6'h23};
        word_valid_in = 1'b1;
        @(negedge clk_in);
        word_in = {`XID_OP_PUSH_LIT, 8'h5A};
        chk({ptr_we_out, ptr_sel_out}, 3'h6);
        chk(ptr_wdata_out, 12'(sub ? ptr2_in - 12'h023 : ptr2_in + 12'h023));
        chk({pc_load_out, stall_fetch_out}, 2'h3);
        chk(pc_wdata_out, stack_top_in);
        @(negedge clk_in);
        word_valid_in = 1'b0;
        chk({handled_out, wr_en_out, ptr_we_out, pc_load_out}, 4'h0);
    endtask

    task automatic t_call;
        issue(`XID_WORD_CALL_W);
        chk({push_out, pc_load_out, stall_fetch_out}, 3'h7);
        chk(push_data_out, 21'(pc_in + 21'h000002));
        chk(pc_wdata_out, {pc_latch_upper_in, pc_latch_high_in, working_reg_in});
        @(negedge clk_in);
        chk({push_out, pc_load_out, ptr_we_out}, 3'h0);
    endtask

    task automatic t_push(input logic [11:0] p2, input logic [7:0] k);
        ptr2_in = p2;
        issue({`XID_OP_PUSH_LIT, k});
        chk({handled_out, wr_en_out, ptr_we_out}, 3'h7);
        chk(wr_addr_out, p2);
        chk(wr_data_out, k);
        chk({ptr_sel_out, ptr_wdata_out}, {2'h2, p2 - 12'h001});
        chk({pc_load_out, stall_fetch_out}, 2'h0);
    endtask

    task automatic t_move(input logic idx, input logic [11:0] p2, input logic [6:0] zs,
                          input logic [11:0] second, input logic [7:0] data, input logic [7:0] exp_data);
        ptr2_in = p2;
        @(negedge clk_in);
        word_in       = {`XID_OP_MOVE_IDX, idx, zs};
        word_valid_in = 1'b1;
        @(negedge clk_in);
        chk({handled_out, rd_en_out, stall_fetch_out, wr_en_out}, 4'hE);
        chk(rd_addr_out, 12'(p2 + zs));
        word_in    = {`XID_SECOND_NIBBLE, second};
        rd_data_in = data;
        @(negedge clk_in);
        word_valid_in = 1'b0;
        chk(wr_en_out, 1'b1);
        chk(wr_addr_out, 12'(idx ? p2 + second[6:0] : second));
        chk(wr_data_out, exp_data);
        chk({ptr_we_out, pc_load_out}, 2'h0);
        @(negedge clk_in);
        chk(wr_en_out, 1'b0);
    endtask

    task automatic t_move_nowrite(input logic idx, input logic [15:0] second);
        ptr2_in = 12'hF80;
        @(negedge clk_in);
        word_in       = {`XID_OP_MOVE_IDX, idx, 7'h01};
        word_valid_in = 1'b1;
        @(negedge clk_in);
        word_in = second;
        @(negedge clk_in);
        word_valid_in = 1'b0;
        chk({handled_out, wr_en_out, ptr_we_out, pc_load_out}, 4'h8);
        chk(stall_fetch_out, 1'b0);
    endtask

    task automatic t_disabled;
        ext_set_config_bit_in = 1'b0;
        issue({`XID_OP_PUSH_LIT, 8'h11});
        chk({handled_out, wr_en_out, ptr_we_out}, 3'h0);
        issue(`XID_WORD_CALL_W);
        chk({handled_out, push_out, pc_load_out}, 3'h0);
        ext_set_config_bit_in = 1'b1;
    endtask

    // ************************************************************
    // Clock, main sequence, watchdog
    // ************************************************************
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    initial begin
        reset_n_in = 1'b0;
        ext_set_config_bit_in = 1'b1;
        word_valid_in = 1'b0;
        word_in = 16'h0000;
        pc_in = 21'h01FFFE;
        stack_top_in = 21'h0ABCDE;
        ptr0_in = 12'h3FF;
        ptr1_in = 12'h7C1;
        ptr2_in = 12'h020;
        working_reg_in = 8'h06;
        pc_latch_high_in = 8'h10;
        pc_latch_upper_in = 5'h1F;
        rd_data_in = 8'h00;
        repeat (16) @(negedge clk_in);
        reset_n_in = 1'b1;
        @(negedge clk_in);
        chk({handled_out, ptr_we_out, pc_load_out, push_out, wr_en_out, rd_en_out}, 6'h00);
        t_ptr_arith();
        t_return(1'b0);
        t_return(1'b1);
        t_call();
        t_push(12'h080, 8'hA5);
        t_push(12'h000, 8'hFF);
        t_move(1'b0, 12'h080, 7'h05, 12'h123, 8'h33, 8'h33);
        t_move(1'b1, 12'h080, 7'h7F, 12'hF86, 8'h5C, 8'h5C);
        t_move(1'b0, 12'hF80, 7'h7C, 12'h456, 8'h77, 8'h00);
        t_move_nowrite(1'b1, 16'hF07C);
        t_move_nowrite(1'b0, 16'h0123);
        t_disabled();
        conclude();
    end

    initial begin
        #(25 * 1000);
        error_cnt++;
        conclude();
    end
endmodule // extended_isa_decode_execute_tb
`default_nettype wire
